// File: hw/sei_pkg.sv
// package of constants and types for the switch and error interrupt control block
package sei_pkg;

	// ==============================================================
	// register map
	localparam logic [11:0] SEI_GS_CTRL_ADDR = 12'h443;
	localparam logic [11:0] SEI_MS_CTRL_ADDR = 12'h447;
	localparam logic [11:0] SEI_EG_CTRL_ADDR = 12'h44B;
	localparam logic [11:0] SEI_GS_VBASE_ADDR = 12'h44F;

	// ==============================================================
	// reset values and fields
	localparam logic [7:0] SEI_GS_CTRL_RST = 8'hF8;
	localparam logic [7:0] SEI_MS_CTRL_RST = 8'hF8;
	localparam logic [7:0] SEI_EG_CTRL_RST = 8'hF8;
	localparam logic [5:0] SEI_GS_ID_RST = 6'h00;
	localparam int SEI_MASK_LSB = 4;
	localparam int SEI_EG_STATE_BIT = 3;
	localparam int SEI_EG_SRC_N = 6;

	// ==============================================================
	// error source codes
	localparam logic [2:0] SEI_EC_ACFAIL = 3'h0;
	localparam logic [2:0] SEI_EC_WPOST = 3'h1;
	localparam logic [2:0] SEI_EC_ARBTO = 3'h2;
	localparam logic [2:0] SEI_EC_SYSFAIL = 3'h3;
	localparam logic [2:0] SEI_EC_IACK = 3'h4;
	localparam logic [2:0] SEI_EC_DMA = 3'h5;

	// acknowledge group select
	typedef enum logic [1:0] {
		SEI_GRP_GS = 2'b00,
		SEI_GRP_MS = 2'b01,
		SEI_GRP_EG = 2'b10,
		SEI_GRP_NONE = 2'b11
	} sei_grp_t;

	// register port request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} sei_req_t;

	// whole block state
	typedef struct packed {
		logic [7:0] gs_ctrl;
		logic [7:0] ms_ctrl;
		logic [7:0] eg_ctrl;
		logic [5:0] gs_id;
		logic [1:0] gs_num;
		logic [3:0] gs_prev;
		logic [3:0] ms_prev;
		logic [3:0] gs_pend;
		logic [3:0] ms_pend;
		logic [5:0] eg_pend;
		logic acf_s1;
		logic acf_s2;
		logic acf_prev;
		logic sf_s1;
		logic sf_s2;
		logic sf_prev;
		logic [7:0] rdata;
		logic [2:0] priority_level_lines;
		logic [7:0] vec;
		logic ack_valid;
		logic ack_hit;
	} sei_state_t;

	localparam sei_state_t SEI_STATE_RST = '{
		gs_ctrl: SEI_GS_CTRL_RST, ms_ctrl: SEI_MS_CTRL_RST,
		eg_ctrl: SEI_EG_CTRL_RST, gs_id: SEI_GS_ID_RST,
		priority_level_lines: 3'h7, acf_s1: 1'b1, acf_s2: 1'b1, acf_prev: 1'b1,
		sf_s1: 1'b1, sf_s2: 1'b1, sf_prev: 1'b1, default: '0
	};

endpackage : sei_pkg

// File: hw/sei_ctrl.sv
// switch and error group interrupt controller with its four registers
`timescale 1ns/100ps
module sei_ctrl (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire sei_pkg::sei_req_t req_i,
	output logic [7:0] rdata_o,
	// interrupt sources
	input wire logic [3:0] gs_i,
	input wire logic [3:0] ms_i,
	input wire logic acfail_n_i,
	input wire logic sysfail_n_i,
	input wire logic wpost_fail_i,
	input wire logic arb_timeout_i,
	input wire logic iack_evt_i,
	input wire logic dma_done_i,
	// requests to the processor
	output logic irq_gs_o,
	output logic irq_ms_o,
	output logic irq_eg_o,
	// acknowledge cycle
	input wire logic ack_req_i,
	input wire sei_pkg::sei_grp_t ack_grp_i,
	output logic ack_valid_o,
	output logic ack_hit_o,
	output logic [2:0] priority_level_lines_o,
	output logic [7:0] ack_vec_o
);

	sei_pkg::sei_state_t s;
	sei_pkg::sei_state_t next_s;
	logic [3:0] gs_live;
	logic [3:0] ms_live;
	logic [5:0] eg_live;
	logic [5:0] eg_src;
	logic [7:0] eg_view;

	// ==============================================================
	// helpers
	function automatic logic [1:0] top4(input logic [3:0] v);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 0; i < 4; i++) begin
			if (v[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction : top4

	function automatic logic [2:0] low6(input logic [5:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = sei_pkg::SEI_EG_SRC_N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : low6

	// ==============================================================
	// live requests: pending and unmasked
	assign gs_live = s.gs_pend & ~s.gs_ctrl[7:sei_pkg::SEI_MASK_LSB];
	assign ms_live = s.ms_pend & ~s.ms_ctrl[7:sei_pkg::SEI_MASK_LSB];
	// mask bits D7..D4 guard codes 0..3; codes 4 and 5 (iack, dma) are never masked
	assign eg_live = s.eg_pend & {2'b11, ~s.eg_ctrl[4], ~s.eg_ctrl[5],
		~s.eg_ctrl[6], ~s.eg_ctrl[7]};
	// readback shows the inverted synchronised system fail line in D3
	assign eg_view = {s.eg_ctrl[7:4], ~s.sf_s2, s.eg_ctrl[2:0]};

	// new events: power fail and system fail on their falling edge
	assign eg_src = {dma_done_i, iack_evt_i, s.sf_prev & ~s.sf_s2,
		arb_timeout_i, wpost_fail_i, s.acf_prev & ~s.acf_s2};

	// ==============================================================
	// next state
	always_comb begin
		next_s = s;
		next_s.ack_valid = 1'b0;
		next_s.ack_hit = 1'b0;
		// the two failure pins pass two flops before any logic reads them; switch and event pins are read directly
		next_s.acf_s1 = acfail_n_i;
		next_s.acf_s2 = s.acf_s1;
		next_s.acf_prev = s.acf_s2;
		next_s.sf_s1 = sysfail_n_i;
		next_s.sf_s2 = s.sf_s1;
		next_s.sf_prev = s.sf_s2;
		next_s.gs_prev = gs_i;
		next_s.ms_prev = ms_i;

		// register writes, address decode
		if (req_i.wr) begin
			if (req_i.addr == sei_pkg::SEI_GS_CTRL_ADDR) begin
				next_s.gs_ctrl = req_i.wdata;
			end else if (req_i.addr == sei_pkg::SEI_MS_CTRL_ADDR) begin
				next_s.ms_ctrl = req_i.wdata;
			end else if (req_i.addr == sei_pkg::SEI_EG_CTRL_ADDR) begin
				next_s.eg_ctrl = req_i.wdata; // D3 is stored, but reads return the state
			end else if (req_i.addr == sei_pkg::SEI_GS_VBASE_ADDR) begin
				next_s.gs_id = req_i.wdata[7:2];
			end
		end

		// register reads answer one cycle later, unmapped reads zero
		next_s.rdata = 8'h00;
		if (req_i.rd) begin
			if (req_i.addr == sei_pkg::SEI_GS_CTRL_ADDR) begin
				next_s.rdata = s.gs_ctrl;
			end else if (req_i.addr == sei_pkg::SEI_MS_CTRL_ADDR) begin
				next_s.rdata = s.ms_ctrl;
			end else if (req_i.addr == sei_pkg::SEI_EG_CTRL_ADDR) begin
				next_s.rdata = eg_view;
			end else if (req_i.addr == sei_pkg::SEI_GS_VBASE_ADDR) begin
				next_s.rdata = {s.gs_id, s.gs_num};
			end
		end

		// acknowledge: clear first, new events are ORed in after so they win
		if (ack_req_i) begin
			next_s.ack_valid = 1'b1;
			next_s.vec = 8'h00;
			case (ack_grp_i)
				sei_pkg::SEI_GRP_GS: begin
					if (|gs_live) begin
						next_s.ack_hit = 1'b1;
						next_s.gs_pend[top4(gs_live)] = 1'b0;
						next_s.gs_num = top4(gs_live);
						next_s.vec = {s.gs_id, top4(gs_live)};
						next_s.priority_level_lines = ~s.gs_ctrl[2:0];
					end
				end
				sei_pkg::SEI_GRP_MS: begin
					if (|ms_live) begin
						next_s.ack_hit = 1'b1;
						next_s.ms_pend[top4(ms_live)] = 1'b0;
						next_s.vec = {6'h00, top4(ms_live)};
						next_s.priority_level_lines = ~s.ms_ctrl[2:0];
					end
				end
				sei_pkg::SEI_GRP_EG: begin
					if (|eg_live) begin
						next_s.ack_hit = 1'b1;
						next_s.eg_pend[low6(eg_live)] = 1'b0;
						next_s.vec = {5'h00, low6(eg_live)};
						next_s.priority_level_lines = ~s.eg_ctrl[2:0];
					end
				end
				default: begin
					next_s.ack_hit = 1'b0;
				end
			endcase
		end

		// latch rising switches and error events; the set beats the clear
		next_s.gs_pend = next_s.gs_pend | (gs_i & ~s.gs_prev);
		next_s.ms_pend = next_s.ms_pend | (ms_i & ~s.ms_prev);
		next_s.eg_pend = next_s.eg_pend | eg_src;
	end

	// ==============================================================
	// state register; reset loads the documented register values
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= sei_pkg::SEI_STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	// ==============================================================
	// outputs
	assign rdata_o = s.rdata;
	assign irq_gs_o = |gs_live;
	assign irq_ms_o = |ms_live;
	assign irq_eg_o = |eg_live;
	assign ack_valid_o = s.ack_valid;
	assign ack_hit_o = s.ack_hit;
	assign priority_level_lines_o = s.priority_level_lines;
	assign ack_vec_o = s.vec;

	// ==============================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_reset_vals;
		@(posedge clk_i) disable iff (1'b0)
		$fell(rst_i) |-> s.gs_ctrl == sei_pkg::SEI_GS_CTRL_RST
			&& s.ms_ctrl == sei_pkg::SEI_MS_CTRL_RST;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("ctrl reset not F8");

	property p_gs_ipl;
		ack_req_i && ack_grp_i == sei_pkg::SEI_GRP_GS && |gs_live
		|=> ack_hit_o && priority_level_lines_o == ~$past(s.gs_ctrl[2:0]);
	endproperty
	a_gs_ipl: assert property (p_gs_ipl) else $error("gs level wrong");

	property p_ms_ipl;
		ack_req_i && ack_grp_i == sei_pkg::SEI_GRP_MS && |ms_live
		|=> ack_hit_o && priority_level_lines_o == ~$past(s.ms_ctrl[2:0]);
	endproperty
	a_ms_ipl: assert property (p_ms_ipl) else $error("ms level wrong");

	property p_eg_ipl;
		ack_req_i && ack_grp_i == sei_pkg::SEI_GRP_EG && |eg_live
		|=> priority_level_lines_o == ~$past(s.eg_ctrl[2:0]) && ack_vec_o[7:3] == 5'h00;
	endproperty
	a_eg_ipl: assert property (p_eg_ipl) else $error("eg level wrong");

	property p_gs_mask;
		(gs_i[3] && !s.gs_prev[3] && s.gs_ctrl[7]) ##1 (s.gs_ctrl[7] && !ack_req_i)
		|-> s.gs_pend[3];
	endproperty
	a_gs_mask: assert property (p_gs_mask) else $error("gs3 not kept pending");

	property p_ms_irq;
		ms_i[0] && !s.ms_prev[0] && !s.ms_ctrl[4] && !req_i.wr |=> irq_ms_o;
	endproperty
	a_ms_irq: assert property (p_ms_irq) else $error("ms0 did not raise");

	property p_acfail;
		$fell(s.acf_s2) && !s.eg_ctrl[7] && !req_i.wr && !ack_req_i |=> irq_eg_o;
	endproperty
	a_acfail: assert property (p_acfail) else $error("power fail lost");

	property p_sysfail_state;
		!s.sf_s2 && req_i.rd && req_i.addr == sei_pkg::SEI_EG_CTRL_ADDR
		|=> rdata_o[sei_pkg::SEI_EG_STATE_BIT];
	endproperty
	a_sysfail_state: assert property (p_sysfail_state) else $error("D3 clear");

	property p_gs_order;
		ack_req_i && ack_grp_i == sei_pkg::SEI_GRP_GS && gs_live[3] && gs_live[2]
		|=> ack_vec_o[1:0] == 2'h3 && s.gs_pend[2];
	endproperty
	a_gs_order: assert property (p_gs_order) else $error("gs order wrong");

	property p_ms_write;
		req_i.wr && req_i.addr == sei_pkg::SEI_MS_CTRL_ADDR |=> s.ms_ctrl == $past(req_i.wdata);
	endproperty
	a_ms_write: assert property (p_ms_write) else $error("ms write lost");

	property p_vbase_read;
		ack_req_i && ack_grp_i == sei_pkg::SEI_GRP_GS && |gs_live ##1 !ack_req_i
		##1 (req_i.rd && req_i.addr == sei_pkg::SEI_GS_VBASE_ADDR && !ack_req_i)
		|=> rdata_o[1:0] == $past(ack_vec_o[1:0]);
	endproperty
	a_vbase_read: assert property (p_vbase_read) else $error("switch number bad");

endmodule : sei_ctrl

// File: testbench/sei_host_model.sv
// host processor model that runs acknowledge cycles on the controller
`timescale 1ns/100ps
module sei_host_model (
	// clock
	input wire logic clk_i,
	// acknowledge request
	output logic ack_req_o,
	output sei_pkg::sei_grp_t ack_grp_o,
	// answer from the controller
	input wire logic ack_valid_i,
	input wire logic ack_hit_i,
	input wire logic [7:0] ack_vec_i,
	input wire logic [2:0] lines_i
);
	// ==============================================================
	// idle: no request, group none, so a stale group is never seen
	initial begin
		ack_req_o = 1'b0;
		ack_grp_o = sei_pkg::SEI_GRP_NONE;
	end

	// one-cycle request, answer taken after the edge that takes it
	task automatic ack(input sei_pkg::sei_grp_t grp, output logic [12:0] ans);
		@(negedge clk_i);
		ack_req_o = 1'b1;
		ack_grp_o = grp;
		@(negedge clk_i);
		ack_req_o = 1'b0;
		ack_grp_o = sei_pkg::SEI_GRP_NONE;
		ans = {ack_valid_i, ack_hit_i, ack_vec_i, lines_i};
	endtask : ack
endmodule : sei_host_model

// File: testbench/sei_ctrl_test.sv
// self-checking bench for the switch and error interrupt controller
`timescale 1ns/100ps
module sei_ctrl_test;
	// ==============================================================
	// design signals, all driven at time zero
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	sei_pkg::sei_req_t req_i = '0;
	logic [7:0] rdata_o;
	logic [3:0] gs_i = 4'h0;
	logic [3:0] ms_i = 4'h0;
	logic acfail_n_i = 1'b1;
	logic sysfail_n_i = 1'b1;
	logic [3:0] evt = 4'h0; // write-post, arbitration, iack, dma pulses
	logic ack_req_i;
	sei_pkg::sei_grp_t ack_grp_i;
	logic irq_gs_o, irq_ms_o, irq_eg_o, ack_valid_o, ack_hit_o;
	logic [2:0] priority_level_lines_o;
	logic [7:0] ack_vec_o;
	logic [12:0] ans;
	logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
	int num_errors = 0;
	int tests_run = 0;

	// 50 MHz clock
	always #10 clk_i = ~clk_i;

	// ==============================================================
	// design and host model
	sei_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .gs_i(gs_i),
		.ms_i(ms_i), .acfail_n_i(acfail_n_i), .sysfail_n_i(sysfail_n_i), .wpost_fail_i(evt[3]),
		.arb_timeout_i(evt[2]), .iack_evt_i(evt[1]), .dma_done_i(evt[0]), .irq_gs_o(irq_gs_o),
		.irq_ms_o(irq_ms_o), .irq_eg_o(irq_eg_o), .ack_req_i(ack_req_i), .ack_grp_i(ack_grp_i),
		.ack_valid_o(ack_valid_o), .ack_hit_o(ack_hit_o),
		.priority_level_lines_o(priority_level_lines_o), .ack_vec_o(ack_vec_o));
	sei_host_model host_u (.clk_i(clk_i), .ack_req_o(ack_req_i), .ack_grp_o(ack_grp_i),
		.ack_valid_i(ack_valid_o), .ack_hit_i(ack_hit_o), .ack_vec_i(ack_vec_o),
		.lines_i(priority_level_lines_o));

	// ==============================================================
	// compare, counting every check
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// one-cycle write strobe; inputs change only at the falling edge
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk_i);
		req_i = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge clk_i);
		req_i = '0;
	endtask : wr

	// read data stands from the taking edge, checked at the next falling edge
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(negedge clk_i);
		req_i = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge clk_i);
		req_i = '0;
		chk(rdata_o, exp);
	endtask : rd

	// acknowledge through the host model; valid must come with the answer
	task automatic ak(input sei_pkg::sei_grp_t g, input logic h, input logic [7:0] v,
		input logic [2:0] l);
		host_u.ack(g, ans);
		chk(ans, {1'b1, h, v, l});
	endtask : ak

	task automatic idle(input int n);
		repeat (n) @(negedge clk_i);
	endtask : idle

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	// ==============================================================
	// hang guard, far beyond the roughly 80 cycles the tests take
	initial begin
		repeat (3000) @(posedge clk_i);
		num_errors++;
		summarize();
	end

	// main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		rd(sei_pkg::SEI_GS_CTRL_ADDR, 8'hF8);
		rd(sei_pkg::SEI_MS_CTRL_ADDR, 8'hF8);
		rd(sei_pkg::SEI_EG_CTRL_ADDR, 8'hF0);
		rd(sei_pkg::SEI_GS_VBASE_ADDR, 8'h00);
		wr(12'h445, 8'h12);
		rd(12'h445, 8'h00);
		rd(sei_pkg::SEI_GS_CTRL_ADDR, 8'hF8);
		$display("test reset and map done");
		// two switches together, highest first, then a miss
		wr(sei_pkg::SEI_GS_VBASE_ADDR, 8'hAB);
		rd(sei_pkg::SEI_GS_VBASE_ADDR, 8'hA8);
		wr(sei_pkg::SEI_GS_CTRL_ADDR, 8'h05);
		gs_i = 4'hC;
		idle(2);
		chk(irq_gs_o, 1'b1);
		ak(sei_pkg::SEI_GRP_GS, 1'b1, 8'hAB, 3'h2);
		rd(sei_pkg::SEI_GS_VBASE_ADDR, 8'hAB);
		ak(sei_pkg::SEI_GRP_GS, 1'b1, 8'hAA, 3'h2);
		ak(sei_pkg::SEI_GRP_GS, 1'b0, 8'h00, 3'h2);
		// masked switches 3 and 0 rise, stay quiet until unmasked
		gs_i = 4'h0;
		wr(sei_pkg::SEI_GS_CTRL_ADDR, 8'h95);
		gs_i = 4'h9;
		idle(2);
		chk(irq_gs_o, 1'b0);
		wr(sei_pkg::SEI_GS_CTRL_ADDR, 8'h03);
		chk(irq_gs_o, 1'b1);
		ak(sei_pkg::SEI_GRP_GS, 1'b1, 8'hAB, 3'h4);
		ak(sei_pkg::SEI_GRP_GS, 1'b1, 8'hA8, 3'h4);
		$display("test global switch done");
		// upper two module switches masked, level 1
		wr(sei_pkg::SEI_MS_CTRL_ADDR, 8'hC1);
		ms_i = 4'hF;
		idle(2);
		chk(irq_ms_o, 1'b1);
		ak(sei_pkg::SEI_GRP_MS, 1'b1, 8'h01, 3'h6);
		ak(sei_pkg::SEI_GRP_MS, 1'b1, 8'h00, 3'h6);
		ak(sei_pkg::SEI_GRP_MS, 1'b0, 8'h00, 3'h6);
		chk(irq_ms_o, 1'b0);
		$display("test module switch done");
		// error group: write-post kept masked, state bit not writable
		wr(sei_pkg::SEI_EG_CTRL_ADDR, 8'h4E);
		rd(sei_pkg::SEI_EG_CTRL_ADDR, 8'h46);
		acfail_n_i = 1'b0;
		sysfail_n_i = 1'b0;
		evt = 4'hF;
		idle(1);
		evt = 4'h0;
		idle(5);
		chk(irq_eg_o, 1'b1);
		rd(sei_pkg::SEI_EG_CTRL_ADDR, 8'h4E);
		for (int i = 0; i < 5; i++) begin
			ak(sei_pkg::SEI_GRP_EG, 1'b1, {5'h00, codes[i]}, 3'h1);
		end
		ak(sei_pkg::SEI_GRP_EG, 1'b0, 8'h00, 3'h1);
		ak(sei_pkg::SEI_GRP_NONE, 1'b0, 8'h00, 3'h1);
		chk(irq_eg_o, 1'b0);
		$display("test error group done");
		summarize();
	end
endmodule : sei_ctrl_test
